/* File: atrb_pkg.sv */
// Constants and carrier types for the converter trim register bank.
// Assumes a single 20 MHz register clock and a 32-bit AXI4-Lite master.
// Contract
// - Input-first offset trims core B under calibration
// - Input-second offset trims core B under calibration
// - Core B offsets apply in both modes
// - Bank 0 gain trim for core A
// - Bank 1 gain trim for core A
// - Bank gain trims used in dual mode
// - Trim defaults load from fuse storage
package atrb_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices and byte addresses
	localparam int unsigned     ADDR_W          = 14;
	localparam logic [11:0]     IDX_OFF_FIRST   = 12'h34C;
	localparam logic [11:0]     IDX_OFF_SECOND  = 12'h34E;
	localparam logic [11:0]     IDX_GAIN_BANK0  = 12'h350;
	localparam logic [11:0]     IDX_GAIN_BANK1  = 12'h351;
	localparam logic [13:0]     ADR_OFF_FIRST   = {IDX_OFF_FIRST, 2'b00};
	localparam logic [13:0]     ADR_OFF_SECOND  = {IDX_OFF_SECOND, 2'b00};
	localparam logic [13:0]     ADR_GAIN_BANK0  = {IDX_GAIN_BANK0, 2'b00};
	localparam logic [13:0]     ADR_GAIN_BANK1  = {IDX_GAIN_BANK1, 2'b00};

	////////////////////////////////////////////////////////////////////////////////
	// Field layout and reset values
	localparam int unsigned     OFF_MSB         = 11;
	localparam int unsigned     GAIN_MSB        = 4;
	localparam logic [3:0]      OFF_RSVD_RST    = 4'h0;
	localparam logic [2:0]      GAIN_RSVD_RST   = 3'h0;
	localparam logic [1:0]      RESP_OKAY       = 2'h0;
	localparam logic [1:0]      RESP_DECERR     = 2'h3;

	typedef enum logic [2:0] {
		ATRB_SEL_NONE,
		ATRB_SEL_OFF_FIRST,
		ATRB_SEL_OFF_SECOND,
		ATRB_SEL_GAIN0,
		ATRB_SEL_GAIN1
	} atrb_sel_t;

	// Defaults delivered by the fuse store
	typedef struct packed {
		logic [11:0] off_first;
		logic [11:0] off_second;
		logic [4:0]  gain_bank0;
		logic [4:0]  gain_bank1;
	} atrb_fuse_t;

	// Corrections driven to the converter cores
	typedef struct packed {
		logic [11:0] core_b_offset;
		logic [4:0]  core_a_bank0_gain;
		logic [4:0]  core_a_bank1_gain;
	} atrb_trim_t;

	typedef struct packed {
		logic [15:0] core_b_input_a_offset_trim;
		logic [15:0] core_b_input_b_offset_trim;
		logic [7:0]  core_a_bank0_dual_gain_trim;
		logic [7:0]  core_a_bank1_dual_gain_trim;
		logic        aw_held;
		logic [13:0] awaddr;
		logic        w_held;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		atrb_trim_t  trim;
	} atrb_state_t;

endpackage

/* File: atrb_bank.sv */
// Trim register bank with an AXI4-Lite slave and registered trim outputs.
// Assumes fuse defaults and mode levels come from logic on the same clock.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
module atrb_bank
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [13:0]           s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [13:0]           s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire atrb_pkg::atrb_fuse_t  fuse_defaults,
	input  wire logic                  fg_cal_enable,
	input  wire logic                  dual_channel_mode,
	input  wire logic                  core_b_on_input_pair_second,
	output atrb_pkg::atrb_trim_t       trim_out
);

	atrb_pkg::atrb_state_t st_r;
	atrb_pkg::atrb_state_t st_nxt;
	logic                  wr_go;
	atrb_pkg::atrb_sel_t   wr_sel;
	atrb_pkg::atrb_sel_t   rd_sel;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode
	function automatic atrb_pkg::atrb_sel_t decode(input logic [13:0] addr);
		unique case (addr)
			atrb_pkg::ADR_OFF_FIRST:  decode = atrb_pkg::ATRB_SEL_OFF_FIRST;
			atrb_pkg::ADR_OFF_SECOND: decode = atrb_pkg::ATRB_SEL_OFF_SECOND;
			atrb_pkg::ADR_GAIN_BANK0: decode = atrb_pkg::ATRB_SEL_GAIN0;
			atrb_pkg::ADR_GAIN_BANK1: decode = atrb_pkg::ATRB_SEL_GAIN1;
			default:                  decode = atrb_pkg::ATRB_SEL_NONE;
		endcase
	endfunction

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] be);
		merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	assign wr_go  = st_r.aw_held && st_r.w_held && !st_r.bvalid;
	assign wr_sel = decode(st_r.awaddr);
	assign rd_sel = decode(s_axi_araddr);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		st_nxt = st_r;
		// Write address and data are taken independently
		if (s_axi_awvalid && st_r.awready)
		begin
			st_nxt.aw_held = 1'b1;
			st_nxt.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready)
		begin
			st_nxt.w_held = 1'b1;
			st_nxt.wdata  = s_axi_wdata;
			st_nxt.wstrb  = s_axi_wstrb;
		end
		if (wr_go)
		begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = atrb_pkg::RESP_OKAY;
			// Each strobed byte lane stored, reserved bits included
			unique case (wr_sel)
				atrb_pkg::ATRB_SEL_OFF_FIRST:
					st_nxt.core_b_input_a_offset_trim =
						merge16(st_r.core_b_input_a_offset_trim, st_r.wdata, st_r.wstrb);
				atrb_pkg::ATRB_SEL_OFF_SECOND:
					st_nxt.core_b_input_b_offset_trim =
						merge16(st_r.core_b_input_b_offset_trim, st_r.wdata, st_r.wstrb);
				atrb_pkg::ATRB_SEL_GAIN0:
					if (st_r.wstrb[0])
						st_nxt.core_a_bank0_dual_gain_trim = st_r.wdata[7:0];
				atrb_pkg::ATRB_SEL_GAIN1:
					if (st_r.wstrb[0])
						st_nxt.core_a_bank1_dual_gain_trim = st_r.wdata[7:0];
				atrb_pkg::ATRB_SEL_NONE:
					st_nxt.bresp = atrb_pkg::RESP_DECERR;
			endcase
		end
		if (st_r.bvalid && s_axi_bready)
			st_nxt.bvalid = 1'b0;
		st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_held && !st_nxt.bvalid;

		// Read path
		if (s_axi_arvalid && st_r.arready)
		begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid  = 1'b1;
			st_nxt.rresp   = atrb_pkg::RESP_OKAY;
			st_nxt.rdata   = 32'h0000_0000;
			unique case (rd_sel)
				atrb_pkg::ATRB_SEL_OFF_FIRST:
					st_nxt.rdata[15:0] = st_r.core_b_input_a_offset_trim;
				atrb_pkg::ATRB_SEL_OFF_SECOND:
					st_nxt.rdata[15:0] = st_r.core_b_input_b_offset_trim;
				atrb_pkg::ATRB_SEL_GAIN0:
					st_nxt.rdata[7:0] = st_r.core_a_bank0_dual_gain_trim;
				atrb_pkg::ATRB_SEL_GAIN1:
					st_nxt.rdata[7:0] = st_r.core_a_bank1_dual_gain_trim;
				atrb_pkg::ATRB_SEL_NONE:
					st_nxt.rresp = atrb_pkg::RESP_DECERR;
			endcase
		end
		else if (st_r.rvalid && s_axi_rready)
		begin
			st_nxt.rvalid  = 1'b0;
			st_nxt.arready = 1'b1;
		end

		// Core B offset follows the sampled pair under calibration, zero otherwise, in either mode
		if (!fg_cal_enable)
			st_nxt.trim.core_b_offset = 12'h000;
		else if (core_b_on_input_pair_second)
			st_nxt.trim.core_b_offset =
				st_r.core_b_input_b_offset_trim[atrb_pkg::OFF_MSB:0];
		else
			st_nxt.trim.core_b_offset =
				st_r.core_b_input_a_offset_trim[atrb_pkg::OFF_MSB:0];
		// Bank gains driven only in dual mode
		st_nxt.trim.core_a_bank0_gain = dual_channel_mode ?
			st_r.core_a_bank0_dual_gain_trim[atrb_pkg::GAIN_MSB:0] : 5'h00;
		st_nxt.trim.core_a_bank1_gain = dual_channel_mode ?
			st_r.core_a_bank1_dual_gain_trim[atrb_pkg::GAIN_MSB:0] : 5'h00;

		// Reset reloads fused defaults
		if (!aresetn)
		begin
			st_nxt = '0;
			st_nxt.core_b_input_a_offset_trim  = {atrb_pkg::OFF_RSVD_RST, fuse_defaults.off_first};
			st_nxt.core_b_input_b_offset_trim  = {atrb_pkg::OFF_RSVD_RST, fuse_defaults.off_second};
			st_nxt.core_a_bank0_dual_gain_trim = {atrb_pkg::GAIN_RSVD_RST, fuse_defaults.gain_bank0};
			st_nxt.core_a_bank1_dual_gain_trim = {atrb_pkg::GAIN_RSVD_RST, fuse_defaults.gain_bank1};
			st_nxt.awready = 1'b1;
			st_nxt.wready  = 1'b1;
			st_nxt.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		st_r <= st_nxt;
	end

	assign s_axi_awready = st_r.awready;
	assign s_axi_wready  = st_r.wready;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rresp   = st_r.rresp;
	assign s_axi_rdata   = st_r.rdata;
	assign trim_out      = st_r.trim;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_off_first;
		aresetn && fg_cal_enable && !core_b_on_input_pair_second
			|=> trim_out.core_b_offset == $past(st_r.core_b_input_a_offset_trim[11:0]);
	endproperty
	a_off_first: assert property (p_off_first) else $error("core B first-pair offset wrong");

	property p_off_second;
		aresetn && fg_cal_enable && core_b_on_input_pair_second
			|=> trim_out.core_b_offset == $past(st_r.core_b_input_b_offset_trim[11:0]);
	endproperty
	a_off_second: assert property (p_off_second) else $error("core B second-pair offset wrong");

	// Single mode uses the same per-pair offset as dual mode
	property p_off_single;
		aresetn && fg_cal_enable && !dual_channel_mode
			|=> trim_out.core_b_offset == ($past(core_b_on_input_pair_second) ?
			$past(st_r.core_b_input_b_offset_trim[11:0]) :
			$past(st_r.core_b_input_a_offset_trim[11:0]));
	endproperty
	a_off_single: assert property (p_off_single) else $error("core B offset lost in single mode");

	property p_gain0;
		aresetn && dual_channel_mode |=> trim_out.core_a_bank0_gain
			== $past(st_r.core_a_bank0_dual_gain_trim[4:0]);
	endproperty
	a_gain0: assert property (p_gain0) else $error("bank 0 gain wrong");

	property p_gain1;
		aresetn && dual_channel_mode |=> trim_out.core_a_bank1_gain
			== $past(st_r.core_a_bank1_dual_gain_trim[4:0]);
	endproperty
	a_gain1: assert property (p_gain1) else $error("bank 1 gain wrong");

	property p_gain_dual_only;
		!dual_channel_mode |=> trim_out.core_a_bank0_gain == 5'h00
			&& trim_out.core_a_bank1_gain == 5'h00;
	endproperty
	a_gain_dual_only: assert property (p_gain_dual_only) else $error("gain outside dual mode");

	property p_fuse_load;
		$rose(aresetn) |-> st_r.core_b_input_a_offset_trim == {4'h0, $past(fuse_defaults.off_first)}
			&& st_r.core_a_bank1_dual_gain_trim == {3'h0, $past(fuse_defaults.gain_bank1)};
	endproperty
	a_fuse_load: assert property (p_fuse_load) else $error("fuse default not loaded");

	property p_hold;
		!(wr_go && wr_sel == atrb_pkg::ATRB_SEL_OFF_SECOND)
			|=> $stable(st_r.core_b_input_b_offset_trim);
	endproperty
	a_hold: assert property (p_hold) else $error("offset trim changed without write");

	property p_write_resp;
		wr_go |=> s_axi_bvalid ##0 !s_axi_awready [*1];
	endproperty
	a_write_resp: assert property (p_write_resp) else $error("write response missing");

endmodule

/* File: testbench.sv */
// Self-checking bench for the converter trim register bank.
// Assumes atrb_pkg and atrb_bank are compiled first; one 20 MHz clock.
`timescale 1ns/1ns
module testbench;

////////////////////////////////////////////////////////////////////////////////
logic                  aclk;
logic                  aresetn;
logic [13:0]           awaddr;
logic                  awvalid;
logic [31:0]           wdata;
logic [3:0]            wstrb;
logic                  wvalid;
logic [13:0]           araddr;
logic                  arvalid;
logic                  fg_cal_enable;
logic                  dual_channel_mode;
logic                  on_second;
atrb_pkg::atrb_fuse_t  fuse;
atrb_pkg::atrb_trim_t  trim_out;
logic                  s_axi_awready;
logic                  s_axi_wready;
logic                  s_axi_bvalid;
logic                  s_axi_arready;
logic                  s_axi_rvalid;
logic [1:0]            s_axi_bresp;
logic [1:0]            s_axi_rresp;
logic [31:0]           s_axi_rdata;
int                    failures;
int                    total_checks;

atrb_bank u_atrb_bank
(
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
	.s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
	.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(1'b1), .fuse_defaults(fuse), .fg_cal_enable(fg_cal_enable),
	.dual_channel_mode(dual_channel_mode), .core_b_on_input_pair_second(on_second),
	.trim_out(trim_out)
);

////////////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
	total_checks++;
	if (g !== e)
	begin
		failures++;
		$display("MISMATCH %s expected %h seen %h", nm, e, g);
	end
endtask

task automatic report_and_stop;
	$display("checks %0d mismatches %0d", total_checks, failures);
	if (failures == 0 && total_checks > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask

// Ready and valid sampled mid-cycle, released after the edge
task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s,
	input logic [1:0] er);
	bit ha, hw, dn;
	awaddr <= a;
	wdata <= d;
	wstrb <= s;
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	dn = 0;
	for (int n = 0; n < 50 && !dn; n++)
	begin
		@(negedge aclk);
		ha = awvalid && s_axi_awready;
		hw = wvalid && s_axi_wready;
		dn = s_axi_bvalid;
		if (dn)
			chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		@(posedge aclk);
		if (ha)
			awvalid <= 1'b0;
		if (hw)
			wvalid <= 1'b0;
	end
	if (!dn)
		chk("bvalid", 32'h1, 32'h0);
endtask

task automatic rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er);
	bit ha, dn;
	araddr <= a;
	arvalid <= 1'b1;
	dn = 0;
	for (int n = 0; n < 50 && !dn; n++)
	begin
		@(negedge aclk);
		ha = arvalid && s_axi_arready;
		dn = s_axi_rvalid;
		if (dn)
			chk({"rdata ", $sformatf("%h", a)}, ed, s_axi_rdata);
		if (dn)
			chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		@(posedge aclk);
		if (ha)
			arvalid <= 1'b0;
	end
	if (!dn)
		chk("rvalid", 32'h1, 32'h0);
endtask

task automatic do_reset;
	@(posedge aclk);
	aresetn <= 1'b0;
	repeat (4) @(posedge aclk);
	aresetn <= 1'b1;
	@(posedge aclk);
endtask

////////////////////////////////////////////////////////////////////////////////
initial
begin
	aclk = 1'b0;
	forever #25 aclk = ~aclk;
end

initial
begin
	#(50 * 4000);
	failures++;
	report_and_stop();
end

initial
begin
	logic [11:0] ecb;
	logic [9:0]  eg;
	{aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
	{fg_cal_enable, dual_channel_mode, on_second} = 3'b110;
	fuse = '{off_first: 12'hA5C, off_second: 12'h3B7, gain_bank0: 5'h15,
		gain_bank1: 5'h0A};
	do_reset();
	rd(atrb_pkg::ADR_OFF_FIRST, 32'h00000A5C, 2'h0);
	rd(atrb_pkg::ADR_OFF_SECOND, 32'h000003B7, 2'h0);
	rd(atrb_pkg::ADR_GAIN_BANK0, 32'h00000015, 2'h0);
	rd(atrb_pkg::ADR_GAIN_BANK1, 32'h0000000A, 2'h0);
	wr(atrb_pkg::ADR_OFF_FIRST, 32'hFFFFF123, 4'hF, 2'h0);
	wr(atrb_pkg::ADR_OFF_SECOND, 32'h00005E6D, 4'h1, 2'h0);
	wr(atrb_pkg::ADR_GAIN_BANK0, 32'h000000FF, 4'h1, 2'h0);
	wr(atrb_pkg::ADR_GAIN_BANK1, 32'h0000001F, 4'hE, 2'h0);
	wr(14'hD34, 32'h0000FFFF, 4'hF, 2'h3);
	rd(14'hD34, 32'h0, 2'h3);
	rd(atrb_pkg::ADR_OFF_FIRST, 32'h0000F123, 2'h0);
	rd(atrb_pkg::ADR_OFF_SECOND, 32'h0000036D, 2'h0);
	rd(atrb_pkg::ADR_GAIN_BANK0, 32'h000000FF, 2'h0);
	rd(atrb_pkg::ADR_GAIN_BANK1, 32'h0000000A, 2'h0);
	// Every calibration, pair and mode combination
	for (int i = 0; i < 8; i++)
	begin
		fg_cal_enable <= i[2];
		on_second <= i[1];
		dual_channel_mode <= i[0];
		@(posedge aclk);
		@(posedge aclk);
		@(negedge aclk);
		ecb = !i[2] ? 12'h0 : (i[1] ? 12'h36D : 12'h123);
		eg = i[0] ? {5'h1F, 5'h0A} : 10'h0;
		chk("trim_out", {10'h0, ecb, eg}, {10'h0, trim_out});
		@(posedge aclk);
	end
	// Second reset reloads from new fuse contents
	fuse <= '{off_first: 12'h5A3, off_second: 12'hC48, gain_bank0: 5'h0E,
		gain_bank1: 5'h11};
	do_reset();
	rd(atrb_pkg::ADR_OFF_FIRST, 32'h000005A3, 2'h0);
	rd(atrb_pkg::ADR_OFF_SECOND, 32'h00000C48, 2'h0);
	rd(atrb_pkg::ADR_GAIN_BANK0, 32'h0000000E, 2'h0);
	rd(atrb_pkg::ADR_GAIN_BANK1, 32'h00000011, 2'h0);
	report_and_stop();
end

endmodule
